// ### verilog/nvs_defs.svh
// Offsets, fields, codes and reset values of the nonvolatile settings block
`ifndef NVS_DEFS_SVH
`define NVS_DEFS_SVH
`define NVS_A_CMD 8'h00
`define NVS_A_STAT 8'h04
`define NVS_A_RESULT 8'h08
`define NVS_A_IDIN0 8'h0c
`define NVS_A_IDIN2 8'h14
`define NVS_A_IDLEN 8'h18
`define NVS_A_IDOUT0 8'h1c
`define NVS_A_IDOUT2 8'h24
`define NVS_A_WORK 8'h28
`define NVS_A_RXCH 8'h2c
`define NVS_F_OP 0
`define NVS_F_IDX 8
`define NVS_F_VAL 16
`define NVS_OP_IDWR 4'h1
`define NVS_OP_IDRD 4'h2
`define NVS_OP_SAVE 4'h3
`define NVS_OP_RDB 4'h4
`define NVS_OP_SETV 4'h5
`define NVS_OP_ON 4'h6
`define NVS_OP_OFF 4'h7
`define NVS_OP_SUMM 4'h8
`define NVS_OP_DEF 4'h9
`define NVS_OP_WS 4'ha
`define NVS_ID_LEN 4'hc
`define NVS_CH_LO 8'h21
`define NVS_CH_HI 8'h5f
`define NVS_PP_LAST 6'h2f
`define NVS_PP_ALL 8'hff
`define NVS_PP_MA 6'h00
`define NVS_PP_HDR 6'h01
`define NVS_PP_TMO 6'h03
`define NVS_PP_AT 6'h04
`define NVS_PP_TESTER 6'h06
`define NVS_PP_BAUD 6'h0c
`define NVS_PP_TERM 6'h0d
`define NVS_PP_FILL 6'h26
`define NVS_PP_IMM 6'h2f
`define NVS_DEF_OFF 8'hff
`define NVS_DEF_TMO 8'h32
`define NVS_DEF_AT 8'h01
`define NVS_DEF_TESTER 8'hf1
`define NVS_DEF_TERM 8'h0d
`define NVS_DEF_FILL 8'h00
`define NVS_HDR_ON 8'h00
`define NVS_FLAG_ON 8'h4e
`define NVS_FLAG_OFF 8'h46
`endif

// ### verilog/nvs_pkg.sv
// Types and parameter tables of the nonvolatile settings block
`include "nvs_defs.svh"
package nvs_pkg;
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RD = 5'b00010,
        S_AP = 5'b00100,
        S_SRD = 5'b01000,
        S_SWAIT = 5'b10000
    } state_t;
    typedef enum logic [3:0] {
        PT_I = 4'b0001,
        PT_D = 4'b0010,
        PT_R = 4'b0100,
        PT_P = 4'b1000
    } ptype_t;
    function automatic ptype_t param_type(input logic [5:0] idx);
        case (idx)
            `NVS_PP_MA, `NVS_PP_TESTER, `NVS_PP_TERM: param_type = PT_R;
            `NVS_PP_BAUD: param_type = PT_P;
            `NVS_PP_IMM: param_type = PT_I;
            default: param_type = PT_D;
        endcase
    endfunction : param_type
    function automatic logic [7:0] param_default(input logic [5:0] idx);
        case (idx)
            `NVS_PP_TMO: param_default = `NVS_DEF_TMO;
            `NVS_PP_AT: param_default = `NVS_DEF_AT;
            `NVS_PP_TESTER: param_default = `NVS_DEF_TESTER;
            `NVS_PP_TERM: param_default = `NVS_DEF_TERM;
            `NVS_PP_FILL: param_default = `NVS_DEF_FILL;
            default: param_default = `NVS_DEF_OFF;
        endcase
    endfunction : param_default
endpackage : nvs_pkg

// ### verilog/param_mem.sv
// Parameter value store with registered read port
`timescale 1ns/1ps
module param_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 48,
    parameter int AW = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rdata_r;
    assign rdata = rdata_r;
    // Power-style reset loads the factory values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= WIDTH'(nvs_pkg::param_default(6'(i)));
            end
            rdata_r <= '0;
        end else begin
            if (we) begin
                mem_r[addr] <= wdata;
            end
            rdata_r <= mem_r[addr];
        end
    end
endmodule : param_mem

// ### verilog/nonvolatile_settings_commands.sv
// Command handling of identifier, user byte and programmable parameter stores
`timescale 1ns/1ps
`include "nvs_defs.svh"
module nonvolatile_settings_commands #(
    parameter int PP_NUM = 48
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic header_display_setting,
    output logic [7:0] filler_byte,
    output logic [7:0] terminator_char
);
    nvs_pkg::state_t st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic [PP_NUM-1:0] en_r;
    logic [95:0] idin_r, id_r;
    logic [3:0] idlen_r;
    logic id_set_r, err_r, sum_v_r, term_hit_r, hdr_r;
    logic [7:0] ubyte_r, fill_r, term_r;
    logic [23:0] result_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic [7:0] mem_q;
    logic [11:0] ch_ok;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= `NVS_A_RXCH);
    endfunction : addr_ok

    function automatic logic op_err(input logic [3:0] o, input logic idg,
                                    input logic ids, input logic ixo, input logic all);
        case (o)
            `NVS_OP_IDWR: op_err = !idg;
            `NVS_OP_IDRD: op_err = !ids;
            `NVS_OP_SETV, `NVS_OP_ON: op_err = !ixo;
            `NVS_OP_OFF: op_err = !(ixo || all);
            `NVS_OP_SAVE, `NVS_OP_RDB, `NVS_OP_SUMM,
            `NVS_OP_DEF, `NVS_OP_WS: op_err = 1'b0;
            default: op_err = 1'b1;
        endcase
    endfunction : op_err

    // Bus phases
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_r;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire busy = st_r != nvs_pkg::S_IDLE;
    wire cmd_go = wr && paddr == `NVS_A_CMD && !busy;
    wire [3:0] op = pwdata[`NVS_F_OP +: 4];
    wire [7:0] c_idx = pwdata[`NVS_F_IDX +: 8];
    wire [7:0] c_val = pwdata[`NVS_F_VAL +: 8];
    wire [5:0] c_pp = c_idx[5:0];
    wire idx_ok = c_idx < 8'(PP_NUM);
    wire all_off = c_idx == `NVS_PP_ALL;

    // Identifier character and length checks
    for (genvar g = 0; g < 12; g++) begin : g_ch
        assign ch_ok[g] = idin_r[8*g +: 8] >= `NVS_CH_LO
            && idin_r[8*g +: 8] <= `NVS_CH_HI;
    end
    wire id_good = &ch_ok && idlen_r == `NVS_ID_LEN && !id_set_r;
    wire c_err = op_err(op, id_good, id_set_r, idx_ok, all_off);
    wire on_imm = op == `NVS_OP_ON && idx_ok
        && nvs_pkg::param_type(c_pp) == nvs_pkg::PT_I;
    wire walk_go = op == `NVS_OP_DEF || op == `NVS_OP_WS || on_imm;
    wire walk_end = cnt_r == `NVS_PP_LAST || mask_r == nvs_pkg::PT_I;
    wire mem_we = cmd_go && op == `NVS_OP_SETV && idx_ok;
    // Read ahead by one cycle so the registered read data matches cnt_r
    wire [5:0] mem_addr = mem_we ? c_pp : cnt_nxt;
    wire sum_pop = rd && paddr == `NVS_A_RESULT && st_r == nvs_pkg::S_SWAIT;

    // Apply step of a load walk
    wire [7:0] ap_val = en_r[cnt_r] ? mem_q : nvs_pkg::param_default(cnt_r);
    wire ap_take = st_r == nvs_pkg::S_AP
        && |(4'(nvs_pkg::param_type(cnt_r)) & mask_r);
    wire cur_en = en_r[cnt_r];
    wire [7:0] flag = en_r[cnt_r] ? `NVS_FLAG_ON : `NVS_FLAG_OFF;

    param_mem #(.WIDTH(8), .DEPTH(PP_NUM), .AW(6)) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(c_val),
        .rdata(mem_q)
    );

    // Register read selection
    wire [7:0] wi = paddr - `NVS_A_IDIN0;
    wire [7:0] wo = paddr - `NVS_A_IDOUT0;
    wire in_idin = paddr >= `NVS_A_IDIN0 && paddr <= `NVS_A_IDIN2;
    wire in_idout = paddr >= `NVS_A_IDOUT0 && paddr <= `NVS_A_IDOUT2;
    wire [31:0] stat_w = {27'h0, term_hit_r, sum_v_r, id_set_r, err_r, busy};
    wire [31:0] id_word = id_set_r ? id_r[32*wo[3:2] +: 32] : 32'h0;
    wire [31:0] rd_word =
        !addr_ok(paddr) ? 32'h0 :
        paddr == `NVS_A_STAT ? stat_w :
        paddr == `NVS_A_RESULT ? {8'h0, result_r} :
        in_idin ? idin_r[32*wi[3:2] +: 32] :
        paddr == `NVS_A_IDLEN ? {28'h0, idlen_r} :
        in_idout ? id_word :
        paddr == `NVS_A_WORK ? {8'h0, term_r, fill_r, 7'h0, hdr_r} : 32'h0;
    wire bad = !addr_ok(paddr) || (pwrite && paddr == `NVS_A_CMD && busy);

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign header_display_setting = hdr_r;
    assign filler_byte = fill_r;
    assign terminator_char = term_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & bad;
            prdata_r <= setup ? rd_word : 32'h0;
        end
    end

    // Sequencer
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        mask_nxt = mask_r;
        case (st_r)
            nvs_pkg::S_IDLE: begin
                if (cmd_go && op == `NVS_OP_SUMM) begin
                    st_nxt = nvs_pkg::S_SRD;
                    cnt_nxt = 6'h0;
                end else if (cmd_go && walk_go) begin
                    st_nxt = nvs_pkg::S_RD;
                    cnt_nxt = on_imm ? c_pp : 6'h0;
                    mask_nxt = op == `NVS_OP_DEF ? nvs_pkg::PT_D :
                        op == `NVS_OP_WS ? (nvs_pkg::PT_D | nvs_pkg::PT_R) :
                        nvs_pkg::PT_I;
                end
            end
            nvs_pkg::S_RD: st_nxt = nvs_pkg::S_AP;
            nvs_pkg::S_AP: begin
                st_nxt = walk_end ? nvs_pkg::S_IDLE : nvs_pkg::S_RD;
                cnt_nxt = cnt_r + 6'h1;
            end
            nvs_pkg::S_SRD: st_nxt = nvs_pkg::S_SWAIT;
            nvs_pkg::S_SWAIT: begin
                if (sum_pop) begin
                    st_nxt = cnt_r == `NVS_PP_LAST ? nvs_pkg::S_IDLE : nvs_pkg::S_SRD;
                    cnt_nxt = cnt_r + 6'h1;
                end
            end
            default: st_nxt = nvs_pkg::S_IDLE;
        endcase
    end

    // Power-style reset starts a full load walk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= nvs_pkg::S_RD;
            cnt_r <= 6'h0;
            mask_r <= 4'hf;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Identifier and user byte stores
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idin_r <= 96'h0;
            idlen_r <= 4'h0;
            id_r <= 96'h0;
            id_set_r <= 1'b0;
            ubyte_r <= 8'h0;
        end else begin
            if (wr && in_idin) begin
                idin_r[32*wi[3:2] +: 32] <= pwdata;
            end
            if (wr && paddr == `NVS_A_IDLEN) begin
                idlen_r <= pwdata[3:0];
            end
            if (cmd_go && op == `NVS_OP_IDWR && id_good) begin
                id_r <= idin_r;
                id_set_r <= 1'b1;
            end
            if (cmd_go && op == `NVS_OP_SAVE) begin
                ubyte_r <= c_val;
            end
        end
    end

    // Enables, answers and summary entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= '0;
            err_r <= 1'b0;
            result_r <= 24'h0;
            sum_v_r <= 1'b0;
        end else begin
            if (cmd_go) begin
                err_r <= c_err;
            end
            if (cmd_go && op == `NVS_OP_ON && idx_ok) begin
                en_r[c_pp] <= 1'b1;
            end
            if (cmd_go && op == `NVS_OP_OFF && all_off) begin
                en_r <= '0;
            end else if (cmd_go && op == `NVS_OP_OFF && idx_ok) begin
                en_r[c_pp] <= 1'b0;
            end
            if (cmd_go && op == `NVS_OP_RDB) begin
                result_r <= {16'h0, ubyte_r};
            end else if (st_r == nvs_pkg::S_SRD) begin
                result_r <= {2'b00, cnt_r, flag, mem_q};
            end
            sum_v_r <= st_r == nvs_pkg::S_SRD || (sum_v_r && !sum_pop);
        end
    end

    // Working settings and terminator detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_r <= 1'b0;
            fill_r <= `NVS_DEF_FILL;
            term_r <= `NVS_DEF_TERM;
            term_hit_r <= 1'b0;
        end else begin
            if (ap_take && cnt_r == `NVS_PP_HDR) begin
                hdr_r <= ap_val == `NVS_HDR_ON;
            end
            if (ap_take && cnt_r == `NVS_PP_FILL) begin
                fill_r <= ap_val;
            end
            if (ap_take && cnt_r == `NVS_PP_TERM) begin
                term_r <= ap_val;
            end
            if (wr && paddr == `NVS_A_RXCH) begin
                term_hit_r <= pwdata[7:0] == term_r;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_restore;
        cmd_go && (op == `NVS_OP_DEF);
    endsequence
    sequence s_back_idle;
        ##[1:200] (st_r == nvs_pkg::S_IDLE);
    endsequence

    property p_id_unset;
        cmd_go && op == `NVS_OP_IDRD && !id_set_r |=> err_r;
    endproperty
    a_id_unset: assert property (p_id_unset) else $error("unset id not refused");
    property p_id_once;
        id_set_r |=> id_set_r && $stable(id_r);
    endproperty
    a_id_once: assert property (p_id_once) else $error("stored id changed");
    property p_id_read;
        cmd_go && op == `NVS_OP_IDRD && id_set_r |=> !err_r;
    endproperty
    a_id_read: assert property (p_id_read) else $error("id read refused");
    property p_save;
        cmd_go && op == `NVS_OP_SAVE |=> ubyte_r == $past(c_val) && !err_r;
    endproperty
    a_save: assert property (p_save) else $error("user byte not saved");
    property p_rdb;
        cmd_go && op == `NVS_OP_RDB |=> result_r[7:0] == $past(ubyte_r);
    endproperty
    a_rdb: assert property (p_rdb) else $error("user byte read wrong");
    property p_setv;
        mem_we |=> en_r == $past(en_r);
    endproperty
    a_setv: assert property (p_setv) else $error("set value enabled");
    property p_on;
        cmd_go && op == `NVS_OP_ON && idx_ok && !on_imm |=> en_r[$past(c_pp)]
            && $stable(hdr_r) && $stable(fill_r);
    endproperty
    a_on: assert property (p_on) else $error("enable wrong");
    property p_restore;
        s_restore |-> s_back_idle;
    endproperty
    a_restore: assert property (p_restore) else $error("restore stuck");
    property p_all_off;
        cmd_go && op == `NVS_OP_OFF && all_off |=> en_r == '0;
    endproperty
    a_all_off: assert property (p_all_off) else $error("all off failed");
    property p_flag;
        st_r == nvs_pkg::S_SRD |=> result_r[15:8] ==
            ($past(cur_en) ? `NVS_FLAG_ON : `NVS_FLAG_OFF);
    endproperty
    a_flag: assert property (p_flag) else $error("summary flag wrong");
    property p_bad_id;
        cmd_go && op == `NVS_OP_IDWR && !id_good |=> err_r && $stable(id_r);
    endproperty
    a_bad_id: assert property (p_bad_id) else $error("bad id accepted");
endmodule : nonvolatile_settings_commands

// ### verification/apb_host.sv
// Host model issuing APB transfers to the settings block
`timescale 1ns/1ps
module apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer, held until pready is sampled high or 20 wait cycles pass, then flagged as hung
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic hung);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        hung = (n == 20);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_host

// ### verification/testbench.sv
// Self-checking bench of the nonvolatile settings block
`timescale 1ns/1ps
`include "nvs_defs.svh"
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, header_display_setting;
    logic [7:0] paddr, filler_byte, terminator_char;
    logic [31:0] pwdata, prdata;
    int n_mismatch = 0;
    int total_checks = 0;
    always #5 pclk = ~pclk;
    apb_host i_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    nonvolatile_settings_commands i_nonvolatile_settings_commands (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .header_display_setting(header_display_setting), .filler_byte(filler_byte),
        .terminator_char(terminator_char));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic check_err(input logic exp, input logic [31:0] s);
        check("command error flag", {31'h0, exp}, {31'h0, s[1]});
    endtask : check_err
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic h;
        i_apb_host.xfer(w, a, d, r, e, h);
        if (h) begin
            n_mismatch++;
            $display("unexpected hang at address %h", a);
            complete_run();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bus(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        bus(1'b0, a, 32'h0, r, e);
    endtask : rd
    task automatic wait_bit(input int b, input logic v, output logic [31:0] s);
        int n;
        n = 0;
        rd(`NVS_A_STAT, s);
        while (s[b] !== v && n < 100) begin
            n++;
            rd(`NVS_A_STAT, s);
        end
        if (s[b] !== v) begin
            n_mismatch++;
            $display("unexpected status bit %0d stuck", b);
            complete_run();
        end
    endtask : wait_bit
    task automatic cmd(input logic [3:0] op, input logic [7:0] idx, input logic [7:0] val,
                       output logic [31:0] s);
        wr(`NVS_A_CMD, {8'h00, val, idx, 4'h0, op});
        wait_bit(0, 1'b0, s);
    endtask : cmd
    task automatic chk_work(input string what, input logic [31:0] exp);
        logic [31:0] r;
        rd(`NVS_A_WORK, r);
        check(what, exp, r);
        check("working setting pins", exp,
              {8'h00, terminator_char, filler_byte, 7'h0, header_display_setting});
    endtask : chk_work
    function automatic logic [7:0] dflt(input int k);
        case (k)
            3: return 8'h32;
            4: return 8'h01;
            6: return 8'hf1;
            13: return 8'h0d;
            38: return 8'h00;
            default: return 8'hff;
        endcase
    endfunction : dflt
    task automatic t_reset(input logic mid);
        logic [31:0] s;
        if (mid) begin
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        check("outputs in reset", 32'h000d0000,
              {8'h00, terminator_char, filler_byte, 7'h0, header_display_setting});
        presetn <= 1'b1;
        wait_bit(0, 1'b0, s);
        chk_work("work after reset", 32'h000d0000);
    endtask : t_reset
    task automatic t_refusals;
        logic [31:0] r, s;
        logic e;
        bus(1'b0, 8'h30, 32'h0, r, e);
        check("unmapped read", 32'h1, {r[31:1], e});
        bus(1'b1, 8'h02, 32'h0, r, e);
        check("unaligned write error", 32'h1, {31'h0, e});
        wr(`NVS_A_CMD, {28'h0, `NVS_OP_DEF});
        bus(1'b1, `NVS_A_CMD, {28'h0, `NVS_OP_DEF}, r, e);
        check("command while busy", 32'h1, {31'h0, e});
        wait_bit(0, 1'b0, s);
    endtask : t_refusals
    task automatic t_id_store;
        logic [31:0] w[3];
        logic [31:0] s, r;
        for (int k = 0; k < 12; k++) w[k/4][8*(k%4)+:8] = (k == 11) ? 8'h5f : 8'h21 + 8'(5*k);
        cmd(`NVS_OP_IDRD, 8'h00, 8'h00, s);
        check_err(1'b1, s);
        for (int i = 0; i < 3; i++) wr(`NVS_A_IDIN0 + 8'(4*i), w[i]);
        wr(`NVS_A_IDLEN, 32'hb);
        cmd(`NVS_OP_IDWR, 8'h00, 8'h00, s);
        check("short id status", 32'h2, {29'h0, s[2:0]});
        wr(`NVS_A_IDLEN, 32'hc);
        wr(`NVS_A_IDIN2, {8'h60, w[2][23:0]});
        cmd(`NVS_OP_IDWR, 8'h00, 8'h00, s);
        check("bad char status", 32'h2, {29'h0, s[2:0]});
        wr(`NVS_A_IDIN2, w[2]);
        cmd(`NVS_OP_IDWR, 8'h00, 8'h00, s);
        check("good id status", 32'h4, {29'h0, s[2:0]});
        wr(`NVS_A_IDIN0, w[1]);
        cmd(`NVS_OP_IDWR, 8'h00, 8'h00, s);
        check_err(1'b1, s);
        cmd(`NVS_OP_IDRD, 8'h00, 8'h00, s);
        check_err(1'b0, s);
        for (int i = 0; i < 3; i++) begin
            rd(`NVS_A_IDOUT0 + 8'(4*i), r);
            check("stored id", w[i], r);
        end
    endtask : t_id_store
    task automatic t_user_byte;
        logic [31:0] s, r;
        for (int i = 0; i < 2; i++) begin
            cmd(`NVS_OP_SAVE, 8'h00, 8'h7f + 8'(i), s);
            check_err(1'b0, s);
            cmd(`NVS_OP_RDB, 8'h00, 8'h00, s);
            rd(`NVS_A_RESULT, r);
            check("user byte", 32'h7f + i, {24'h0, r[7:0]});
        end
    endtask : t_user_byte
    task automatic t_param_restore;
        logic [31:0] s;
        cmd(`NVS_OP_SETV, 8'h01, `NVS_HDR_ON, s);
        check_err(1'b0, s);
        cmd(`NVS_OP_SETV, 8'h26, 8'haa, s);
        cmd(`NVS_OP_DEF, 8'h00, 8'h00, s);
        chk_work("work after set", 32'h000d0000);
        cmd(`NVS_OP_ON, 8'h01, 8'h00, s);
        check_err(1'b0, s);
        cmd(`NVS_OP_ON, 8'h26, 8'h00, s);
        chk_work("work after enable", 32'h000d0000);
        cmd(`NVS_OP_DEF, 8'h00, 8'h00, s);
        chk_work("work after restore", 32'h000daa01);
    endtask : t_param_restore
    task automatic t_summary;
        logic [31:0] s, r;
        logic [7:0] v, f;
        wr(`NVS_A_CMD, {28'h0, `NVS_OP_SUMM});
        for (int k = 0; k < 48; k++) begin
            wait_bit(3, 1'b1, s);
            rd(`NVS_A_RESULT, r);
            v = (k == 1) ? 8'h00 : (k == 38) ? 8'haa : dflt(k);
            f = (k == 1 || k == 38) ? `NVS_FLAG_ON : `NVS_FLAG_OFF;
            check("summary entry", {10'h0, 6'(k), f, v}, r);
        end
        wait_bit(0, 1'b0, s);
    endtask : t_summary
    task automatic t_terminator;
        logic [31:0] s;
        cmd(`NVS_OP_SETV, 8'h0d, 8'h0a, s);
        cmd(`NVS_OP_ON, 8'h0d, 8'h00, s);
        cmd(`NVS_OP_DEF, 8'h00, 8'h00, s);
        chk_work("term after restore", 32'h000daa01);
        wr(`NVS_A_RXCH, 32'h0d);
        wait_bit(4, 1'b1, s);
        cmd(`NVS_OP_WS, 8'h00, 8'h00, s);
        chk_work("term after soft reset", 32'h000aaa01);
        wr(`NVS_A_RXCH, 32'h0d);
        rd(`NVS_A_STAT, s);
        check("old terminator match", 32'h0, {31'h0, s[4]});
        wr(`NVS_A_RXCH, 32'h0a);
        rd(`NVS_A_STAT, s);
        check("new terminator match", 32'h1, {31'h0, s[4]});
    endtask : t_terminator
    task automatic t_all_off;
        logic [31:0] s;
        cmd(`NVS_OP_ON, 8'h2f, 8'h00, s);
        check_err(1'b0, s);
        cmd(`NVS_OP_OFF, 8'h30, 8'h00, s);
        check_err(1'b1, s);
        cmd(`NVS_OP_OFF, `NVS_PP_ALL, 8'h00, s);
        check_err(1'b0, s);
        cmd(`NVS_OP_WS, 8'h00, 8'h00, s);
        chk_work("work after all off", 32'h000d0000);
    endtask : t_all_off
    initial begin
        repeat (12) @(posedge pclk);
        t_reset(1'b0);
        t_refusals();
        t_id_store();
        t_user_byte();
        t_param_restore();
        t_summary();
        t_terminator();
        t_all_off();
        t_reset(1'b1);
        complete_run();
    end
endmodule : testbench
